// *** src/ofr_pkg.sv ***
// Package for the off-core response filter: field layout, bit positions,
// reset values, request kinds, supplier kinds and product variants.
// Assumes the config register is 64 bits wide and the core gives one request per cycle.
package ofr_pkg;

	// ************************************************************
	// Config register layout
	// ************************************************************
	localparam int CFG_W   = 64;
	localparam int REQ_LSB = 0;
	localparam int REQ_MSB = 15;
	localparam int SUP_LSB = 16;
	localparam int SUP_MSB = 30;
	localparam int SNP_LSB = 31;
	localparam int SNP_MSB = 37;
	localparam int REQ_W   = REQ_MSB - REQ_LSB + 1;
	localparam int SUP_W   = SUP_MSB - SUP_LSB + 1;
	localparam int SNP_W   = SNP_MSB - SNP_LSB + 1;

	localparam logic [CFG_W-1:0] CFG_RESET = 64'h0000_0000_0000_0000;

	// ************************************************************
	// Request-type bit positions
	// ************************************************************
	localparam int REQ_BIT_DEMAND_DATA   = 0;
	localparam int REQ_BIT_DEMAND_OWN    = 1;
	localparam int REQ_BIT_DEMAND_CODE   = 2;
	localparam int REQ_BIT_WRITEBACK     = 3;
	localparam int REQ_BIT_L2PF_DATA     = 4;
	localparam int REQ_BIT_L2PF_OWN      = 5;
	localparam int REQ_BIT_L2PF_CODE     = 6;
	localparam int REQ_BIT_L3PF_DATA     = 7;
	localparam int REQ_BIT_L3PF_OWN      = 8;
	localparam int REQ_BIT_L3PF_CODE     = 9;
	localparam int REQ_BIT_LOCK          = 10;
	localparam int REQ_BIT_STREAM_STORE  = 11;
	localparam int REQ_BIT_OTHER         = 15;

	// Bits 14:12 are reserved
	localparam logic [REQ_W-1:0] REQ_WRITABLE = 16'h8fff;

	// ************************************************************
	// Supplier bit positions, relative to SUP_LSB
	// ************************************************************
	localparam int SUP_REL_ANY        = 0;
	localparam int SUP_REL_NO_SUPPLIER_MATCH    = 1;
	localparam int SUP_REL_LLC_M      = 2;
	localparam int SUP_REL_LLC_E      = 3;
	localparam int SUP_REL_LLC_S      = 4;
	localparam int SUP_REL_LLC_F      = 5;
	localparam int SUP_REL_LOCAL_MEM  = 6;
	localparam int SUP_REL_L4_LOCAL   = 6;
	localparam int SUP_REL_L4_HOP0    = 7;
	localparam int SUP_REL_L4_HOP1    = 8;
	localparam int SUP_REL_L4_FAR     = 9;
	localparam int SUP_REL_REM_HOP0   = 11;
	localparam int SUP_REL_REM_HOP1   = 12;
	localparam int SUP_REL_REM_FAR    = 13;

	// Writable supplier bits per variant; others read zero
	localparam logic [SUP_W-1:0] SUP_WR_CLIENT    = 15'h005f;
	localparam logic [SUP_W-1:0] SUP_WR_CLIENT_L4 = 15'h03df;
	localparam logic [SUP_W-1:0] SUP_WR_SERVER    = 15'h387f;

	// ************************************************************
	// Enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		OFR_VAR_CLIENT,
		OFR_VAR_CLIENT_L4,
		OFR_VAR_SERVER
	} ofr_variant_e;

	typedef enum logic [4:0] {
		OFR_RQ_DEMAND_DATA,
		OFR_RQ_PAGE_WALK,
		OFR_RQ_DEMAND_OWN,
		OFR_RQ_SW_WRITE_PF,
		OFR_RQ_DEMAND_CODE,
		OFR_RQ_L1I_PF,
		OFR_RQ_WRITEBACK,
		OFR_RQ_L2PF_DATA,
		OFR_RQ_L2PF_OWN,
		OFR_RQ_L2PF_CODE,
		OFR_RQ_L3PF_DATA,
		OFR_RQ_L3PF_OWN,
		OFR_RQ_L3PF_CODE,
		OFR_RQ_SPLIT_LOCK,
		OFR_RQ_UNCACHED_LOCK,
		OFR_RQ_STREAM_STORE,
		OFR_RQ_OTHER
	} ofr_req_kind_e;

	typedef enum logic [3:0] {
		OFR_SP_NONE,
		OFR_SP_LLC_M,
		OFR_SP_LLC_E,
		OFR_SP_LLC_S,
		OFR_SP_LLC_F,
		OFR_SP_LOCAL_MEM,
		OFR_SP_L4_LOCAL,
		OFR_SP_L4_HOP0,
		OFR_SP_L4_HOP1,
		OFR_SP_L4_FAR,
		OFR_SP_REM_HOP0,
		OFR_SP_REM_HOP1,
		OFR_SP_REM_FAR
	} ofr_supplier_e;

endpackage

// *** src/ofr_supplier_map.sv ***
// Supplier decoder: turns the reported supplier of a response into a
// registered match vector laid out like the supplier field of the config.
// Assumes the variant input is already settled when responses arrive.
`timescale 1ns/1ps
module ofr_supplier_map (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_nrst,
	input  wire logic                         i_clk_en,
	input  wire logic                         i_valid,
	input  wire ofr_pkg::ofr_variant_e        i_variant,
	input  wire ofr_pkg::ofr_supplier_e       i_supplier,
	output logic [ofr_pkg::SUP_W-1:0]         o_match_vec
);

	// ************************************************************
	// Decode
	// ************************************************************
	logic [ofr_pkg::SUP_W-1:0] vec_d;
	logic                      is_client;
	logic                      is_l4;
	logic                      is_server;

	assign is_client = (i_variant == ofr_pkg::OFR_VAR_CLIENT);
	assign is_l4     = (i_variant == ofr_pkg::OFR_VAR_CLIENT_L4);
	assign is_server = (i_variant == ofr_pkg::OFR_VAR_SERVER);

	always_comb begin
		vec_d = '0;
		if (i_valid) begin
			vec_d[ofr_pkg::SUP_REL_ANY] = 1'b1;
			unique case (i_supplier)
				ofr_pkg::OFR_SP_NONE:      vec_d[ofr_pkg::SUP_REL_NO_SUPPLIER_MATCH] = 1'b1;
				ofr_pkg::OFR_SP_LLC_M:     vec_d[ofr_pkg::SUP_REL_LLC_M] = 1'b1;
				ofr_pkg::OFR_SP_LLC_E:     vec_d[ofr_pkg::SUP_REL_LLC_E] = 1'b1;
				ofr_pkg::OFR_SP_LLC_S:     vec_d[ofr_pkg::SUP_REL_LLC_S] = 1'b1;
				ofr_pkg::OFR_SP_LLC_F:     vec_d[ofr_pkg::SUP_REL_LLC_F] = is_server;
				ofr_pkg::OFR_SP_LOCAL_MEM: vec_d[ofr_pkg::SUP_REL_LOCAL_MEM] = !is_l4;
				ofr_pkg::OFR_SP_L4_LOCAL:  vec_d[ofr_pkg::SUP_REL_L4_LOCAL] = is_l4;
				ofr_pkg::OFR_SP_L4_HOP0:   vec_d[ofr_pkg::SUP_REL_L4_HOP0] = is_l4;
				ofr_pkg::OFR_SP_L4_HOP1:   vec_d[ofr_pkg::SUP_REL_L4_HOP1] = is_l4;
				ofr_pkg::OFR_SP_L4_FAR:    vec_d[ofr_pkg::SUP_REL_L4_FAR] = is_l4;
				ofr_pkg::OFR_SP_REM_HOP0:  vec_d[ofr_pkg::SUP_REL_REM_HOP0] = is_server;
				ofr_pkg::OFR_SP_REM_HOP1:  vec_d[ofr_pkg::SUP_REL_REM_HOP1] = is_server;
				ofr_pkg::OFR_SP_REM_FAR:   vec_d[ofr_pkg::SUP_REL_REM_FAR] = is_server;
				default:                   vec_d[ofr_pkg::SUP_REL_NO_SUPPLIER_MATCH] = is_client;
			endcase
		end
	end

	// ************************************************************
	// Output register
	// ************************************************************
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_match_vec <= '0;
		end else if (i_clk_en) begin
			o_match_vec <= vec_d;
		end
	end

endmodule

// *** src/ofr_filter.sv ***
// Off-core response filter: holds the off-core response config register and
// qualifies each request leaving the core against its three masks.
// Assumes one request per cycle on the request port, the variant strap steady
// through reset release, and a counter outside that takes o_event_q.
//
// Overview of operation
// - Request-type mask is config bits 15:0
// - Supplier mask is config bits 30:16
// - Snoop mask is config bits 37:31
// - Bit 0: demand data and page-walk reads
// - Bit 1: demand ownership and write-intent prefetch
// - Bit 2: demand code and L1I prefetch
// - Bit 3: modified line writebacks
// - Bits 4-6: L2 prefetch data, ownership, code
// - Bits 7-9: L3 prefetch data, ownership, code
// - Bit 10: split or uncached locks
// - Bit 11: streaming stores
// - Bit 15: any other request; 14:12 reserved
// - Supplier bit 16 matches every response
// - Bit 17: no supplier information
// - Bits 18-20: LLC modified, exclusive, shared hit
// - Supplier layout depends on product variant
// - Client: bit 22 local memory, rest reserved
// - Server: forward hit, local, remote hops
`timescale 1ns/1ps
module ofr_filter #(
	parameter int CFG_WIDTH = 64
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_nrst,
	input  wire logic                       i_clk_en,
	input  wire logic [1:0]                 i_variant,
	input  wire logic                       i_cfg_wr_en,
	input  wire logic [CFG_WIDTH-1:0]       i_cfg_wdata,
	input  wire logic                       i_cfg_rd_en,
	input  wire logic                       i_req_valid,
	input  wire ofr_pkg::ofr_req_kind_e     i_req_kind,
	input  wire ofr_pkg::ofr_supplier_e     i_rsp_supplier,
	input  wire logic [ofr_pkg::SNP_W-1:0]  i_rsp_snoop,
	output logic [CFG_WIDTH-1:0]            o_cfg_rdata_q,
	output logic                            o_cfg_programmed_q,
	output logic                            o_event_q
);

	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (CFG_WIDTH != ofr_pkg::CFG_W) begin : g_bad_width
		$error("CFG_WIDTH must equal the config register width");
	end

	// ************************************************************
	// Variant strap, caught after reset release
	// ************************************************************
	ofr_pkg::ofr_variant_e variant_q;
	ofr_pkg::ofr_variant_e variant_d;
	logic                  strap_taken_q;

	assign variant_d = (i_variant == 2'h3) ? ofr_pkg::OFR_VAR_CLIENT
	                                       : ofr_pkg::ofr_variant_e'(i_variant);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			variant_q     <= ofr_pkg::OFR_VAR_CLIENT;
			strap_taken_q <= 1'b0;
		end else if (i_clk_en && !strap_taken_q) begin
			variant_q     <= variant_d;
			strap_taken_q <= 1'b1;
		end
	end

	// ************************************************************
	// Config register
	// ************************************************************
	logic [CFG_WIDTH-1:0]        cfg_q;
	logic [CFG_WIDTH-1:0]        cfg_d;
	logic [ofr_pkg::SUP_W-1:0]   sup_writable;
	logic [ofr_pkg::REQ_W-1:0]   req_mask;
	logic [ofr_pkg::SUP_W-1:0]   sup_mask;
	logic [ofr_pkg::SNP_W-1:0]   snp_mask;

	assign sup_writable =
		(variant_q == ofr_pkg::OFR_VAR_SERVER)    ? ofr_pkg::SUP_WR_SERVER :
		(variant_q == ofr_pkg::OFR_VAR_CLIENT_L4) ? ofr_pkg::SUP_WR_CLIENT_L4 :
		                                            ofr_pkg::SUP_WR_CLIENT;

	always_comb begin
		cfg_d = '0;
		cfg_d[ofr_pkg::REQ_MSB:ofr_pkg::REQ_LSB] =
			i_cfg_wdata[ofr_pkg::REQ_MSB:ofr_pkg::REQ_LSB] & ofr_pkg::REQ_WRITABLE;
		cfg_d[ofr_pkg::SUP_MSB:ofr_pkg::SUP_LSB] =
			i_cfg_wdata[ofr_pkg::SUP_MSB:ofr_pkg::SUP_LSB] & sup_writable;
		cfg_d[ofr_pkg::SNP_MSB:ofr_pkg::SNP_LSB] =
			i_cfg_wdata[ofr_pkg::SNP_MSB:ofr_pkg::SNP_LSB];
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_q              <= ofr_pkg::CFG_RESET;
			o_cfg_programmed_q <= 1'b0;
		end else if (i_clk_en && i_cfg_wr_en) begin
			cfg_q              <= cfg_d;
			o_cfg_programmed_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cfg_rdata_q <= ofr_pkg::CFG_RESET;
		end else if (i_clk_en && i_cfg_rd_en) begin
			o_cfg_rdata_q <= cfg_q;
		end
	end

	assign req_mask = cfg_q[ofr_pkg::REQ_MSB:ofr_pkg::REQ_LSB];
	assign sup_mask = cfg_q[ofr_pkg::SUP_MSB:ofr_pkg::SUP_LSB];
	assign snp_mask = cfg_q[ofr_pkg::SNP_MSB:ofr_pkg::SNP_LSB];

	// ************************************************************
	// Request kind to request-type bit
	// ************************************************************
	function automatic logic [ofr_pkg::REQ_W-1:0] req_onehot(input ofr_pkg::ofr_req_kind_e k);
		logic [ofr_pkg::REQ_W-1:0] v;
		v = '0;
		unique case (k)
			ofr_pkg::OFR_RQ_DEMAND_DATA,
			ofr_pkg::OFR_RQ_PAGE_WALK:     v[ofr_pkg::REQ_BIT_DEMAND_DATA] = 1'b1;
			ofr_pkg::OFR_RQ_DEMAND_OWN,
			ofr_pkg::OFR_RQ_SW_WRITE_PF:   v[ofr_pkg::REQ_BIT_DEMAND_OWN] = 1'b1;
			ofr_pkg::OFR_RQ_DEMAND_CODE,
			ofr_pkg::OFR_RQ_L1I_PF:        v[ofr_pkg::REQ_BIT_DEMAND_CODE] = 1'b1;
			ofr_pkg::OFR_RQ_WRITEBACK:     v[ofr_pkg::REQ_BIT_WRITEBACK] = 1'b1;
			ofr_pkg::OFR_RQ_L2PF_DATA:     v[ofr_pkg::REQ_BIT_L2PF_DATA] = 1'b1;
			ofr_pkg::OFR_RQ_L2PF_OWN:      v[ofr_pkg::REQ_BIT_L2PF_OWN] = 1'b1;
			ofr_pkg::OFR_RQ_L2PF_CODE:     v[ofr_pkg::REQ_BIT_L2PF_CODE] = 1'b1;
			ofr_pkg::OFR_RQ_L3PF_DATA:     v[ofr_pkg::REQ_BIT_L3PF_DATA] = 1'b1;
			ofr_pkg::OFR_RQ_L3PF_OWN:      v[ofr_pkg::REQ_BIT_L3PF_OWN] = 1'b1;
			ofr_pkg::OFR_RQ_L3PF_CODE:     v[ofr_pkg::REQ_BIT_L3PF_CODE] = 1'b1;
			ofr_pkg::OFR_RQ_SPLIT_LOCK,
			ofr_pkg::OFR_RQ_UNCACHED_LOCK: v[ofr_pkg::REQ_BIT_LOCK] = 1'b1;
			ofr_pkg::OFR_RQ_STREAM_STORE:  v[ofr_pkg::REQ_BIT_STREAM_STORE] = 1'b1;
			ofr_pkg::OFR_RQ_OTHER:         v[ofr_pkg::REQ_BIT_OTHER] = 1'b1;
			default:                       v[ofr_pkg::REQ_BIT_OTHER] = 1'b1;
		endcase
		return v;
	endfunction

	// ************************************************************
	// Stage 1: capture request attributes
	// ************************************************************
	logic                      s1_valid_q;
	logic [ofr_pkg::REQ_W-1:0] s1_req_vec_q;
	logic [ofr_pkg::SNP_W-1:0] s1_snoop_q;
	logic [ofr_pkg::SUP_W-1:0] s1_sup_vec;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_valid_q   <= 1'b0;
			s1_req_vec_q <= '0;
			s1_snoop_q   <= '0;
		end else if (i_clk_en) begin
			s1_valid_q   <= i_req_valid;
			s1_req_vec_q <= i_req_valid ? req_onehot(i_req_kind) : '0;
			s1_snoop_q   <= i_req_valid ? i_rsp_snoop : '0;
		end
	end

	ofr_supplier_map u_supplier_map (
		.i_clk_sys   (i_clk_sys),
		.i_nrst      (i_nrst),
		.i_clk_en    (i_clk_en),
		.i_valid     (i_req_valid),
		.i_variant   (variant_q),
		.i_supplier  (i_rsp_supplier),
		.o_match_vec (s1_sup_vec)
	);

	// ************************************************************
	// Stage 2: qualify against the masks
	// ************************************************************
	logic req_hit;
	logic sup_hit;
	logic snp_hit;
	logic event_d;

	assign req_hit = |(s1_req_vec_q & req_mask);
	assign sup_hit = |(s1_sup_vec & sup_mask);
	assign snp_hit = |(s1_snoop_q & snp_mask);
	assign event_d = s1_valid_q && req_hit && sup_hit && snp_hit;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_event_q <= 1'b0;
		end else if (i_clk_en) begin
			o_event_q <= event_d;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	property p_req_field;
		i_clk_en && i_cfg_wr_en |=> cfg_q[15:0] == ($past(i_cfg_wdata[15:0]) & 16'h8fff);
	endproperty
	a_req_field: assert property (p_req_field) else $error("request mask not stored");

	property p_sup_field;
		i_clk_en && i_cfg_wr_en |=> cfg_q[30:16] == ($past(i_cfg_wdata[30:16]) & $past(sup_writable));
	endproperty
	a_sup_field: assert property (p_sup_field) else $error("supplier mask not stored");

	property p_snp_field;
		i_clk_en && i_cfg_wr_en |=> cfg_q[37:31] == $past(i_cfg_wdata[37:31]) && cfg_q[63:38] == '0;
	endproperty
	a_snp_field: assert property (p_snp_field) else $error("snoop mask not stored");

	property p_rsvd_req;
		cfg_q[14:12] == 3'h0;
	endproperty
	a_rsvd_req: assert property (p_rsvd_req) else $error("reserved request bits set");

	property p_demand_data;
		i_clk_en && i_req_valid && i_req_kind == ofr_pkg::OFR_RQ_PAGE_WALK |=> s1_req_vec_q == 16'h0001;
	endproperty
	a_demand_data: assert property (p_demand_data) else $error("page walk not on bit 0");

	property p_any_supplier;
		i_clk_en && i_req_valid |=> s1_sup_vec[0];
	endproperty
	a_any_supplier: assert property (p_any_supplier) else $error("catch-all bit missing");

	property p_client_rsvd;
		variant_q == ofr_pkg::OFR_VAR_CLIENT |-> cfg_q[21] == 1'b0 && cfg_q[30:23] == 8'h00;
	endproperty
	a_client_rsvd: assert property (p_client_rsvd) else $error("client reserved bits set");

	property p_server_far;
		i_clk_en && i_req_valid && variant_q == ofr_pkg::OFR_VAR_SERVER &&
			i_rsp_supplier == ofr_pkg::OFR_SP_REM_FAR |=> s1_sup_vec == 15'h2001;
	endproperty
	a_server_far: assert property (p_server_far) else $error("far remote bit wrong");

	// Request accepted by the first stage this cycle
	logic req_take;
	assign req_take = i_clk_en && i_req_valid;

	property p_demand_own;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_SW_WRITE_PF |=> s1_req_vec_q == 16'h0002;
	endproperty
	a_demand_own: assert property (p_demand_own) else $error("write prefetch not on bit 1");

	property p_code_pf;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_L1I_PF |=> s1_req_vec_q == 16'h0004;
	endproperty
	a_code_pf: assert property (p_code_pf) else $error("code prefetch not on bit 2");

	property p_writeback;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_WRITEBACK |=> s1_req_vec_q == 16'h0008;
	endproperty
	a_writeback: assert property (p_writeback) else $error("writeback not on bit 3");

	property p_l2pf_code;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_L2PF_CODE |=> s1_req_vec_q == 16'h0040;
	endproperty
	a_l2pf_code: assert property (p_l2pf_code) else $error("L2 code prefetch not on bit 6");

	property p_l3pf_code;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_L3PF_CODE |=> s1_req_vec_q == 16'h0200;
	endproperty
	a_l3pf_code: assert property (p_l3pf_code) else $error("L3 code prefetch not on bit 9");

	property p_lock;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_UNCACHED_LOCK |=> s1_req_vec_q == 16'h0400;
	endproperty
	a_lock: assert property (p_lock) else $error("uncached lock not on bit 10");

	property p_stream;
		req_take && i_req_kind == ofr_pkg::OFR_RQ_STREAM_STORE |=> s1_req_vec_q == 16'h0800;
	endproperty
	a_stream: assert property (p_stream) else $error("streaming store not on bit 11");

	property p_no_supplier_match;
		req_take && i_rsp_supplier == ofr_pkg::OFR_SP_NONE |=> s1_sup_vec == 15'h0003;
	endproperty
	a_no_supplier_match: assert property (p_no_supplier_match) else $error("no-supplier bit wrong");

	property p_llc_shared;
		req_take && i_rsp_supplier == ofr_pkg::OFR_SP_LLC_S |=> s1_sup_vec == 15'h0011;
	endproperty
	a_llc_shared: assert property (p_llc_shared) else $error("shared hit bit wrong");

	property p_l4_far;
		req_take && variant_q == ofr_pkg::OFR_VAR_CLIENT_L4 &&
			i_rsp_supplier == ofr_pkg::OFR_SP_L4_FAR |=> s1_sup_vec == 15'h0201;
	endproperty
	a_l4_far: assert property (p_l4_far) else $error("far fourth cache bit wrong");

	property p_count_match;
		i_clk_en && s1_valid_q |=> o_event_q == $past(req_hit && sup_hit && snp_hit);
	endproperty
	a_count_match: assert property (p_count_match) else $error("count not qualified");

	property p_no_count_idle;
		i_clk_en && !s1_valid_q |=> !o_event_q;
	endproperty
	a_no_count_idle: assert property (p_no_count_idle) else $error("count without request");

	c_event:      cover property (o_event_q);
	c_req_reject: cover property (i_clk_en && s1_valid_q && !req_hit && sup_hit);
	c_sup_reject: cover property (i_clk_en && s1_valid_q && req_hit && !sup_hit);
	c_server:     cover property (variant_q == ofr_pkg::OFR_VAR_SERVER && o_event_q);
	c_l4:         cover property (variant_q == ofr_pkg::OFR_VAR_CLIENT_L4 && o_event_q);

endmodule

// *** tb/ofr_filter_tb_top.sv ***
// Self-checking bench for the off-core response filter: config masking per
// variant, request-type and supplier selection, snoop overlap and clock enable.
// Assumes the design body carries its own assertions; no separate checker here.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("FAIL %s expected %0h seen %0h", nm, e, g); end end

module ofr_filter_tb_top;
	logic                    i_clk_sys;
	logic                    i_nrst;
	logic                    i_clk_en;
	logic [1:0]              i_variant;
	logic                    i_cfg_wr_en;
	logic [63:0]             i_cfg_wdata;
	logic                    i_cfg_rd_en;
	logic                    i_req_valid;
	ofr_pkg::ofr_req_kind_e  i_req_kind;
	ofr_pkg::ofr_supplier_e  i_rsp_supplier;
	logic [6:0]              i_rsp_snoop;
	logic [63:0]             o_cfg_rdata_q;
	logic                    o_cfg_programmed_q;
	logic                    o_event_q;
	int                      failures;
	int                      checked;
	int                      cycles;
	// Writable supplier bits per variant, code 3 behaves as client
	logic [14:0]             sup_wr [4] = '{15'h005f, 15'h03df, 15'h387f, 15'h005f};

	ofr_filter #(.CFG_WIDTH(64)) ofr_filter_inst (
		.i_clk_sys          (i_clk_sys),
		.i_nrst             (i_nrst),
		.i_clk_en           (i_clk_en),
		.i_variant          (i_variant),
		.i_cfg_wr_en        (i_cfg_wr_en),
		.i_cfg_wdata        (i_cfg_wdata),
		.i_cfg_rd_en        (i_cfg_rd_en),
		.i_req_valid        (i_req_valid),
		.i_req_kind         (i_req_kind),
		.i_rsp_supplier     (i_rsp_supplier),
		.i_rsp_snoop        (i_rsp_snoop),
		.o_cfg_rdata_q      (o_cfg_rdata_q),
		.o_cfg_programmed_q (o_cfg_programmed_q),
		.o_event_q          (o_event_q)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [63:0] cfg(input logic [15:0] r, input logic [14:0] s,
		input logic [6:0] n);
		return {26'h0, n, s, r};
	endfunction

	// Expected request bit of each request kind
	function automatic int req_bit(input int k);
		case (k)
			0, 1: return 0;
			2, 3: return 1;
			4, 5: return 2;
			6: return 3;
			13, 14: return 10;
			15: return 11;
			16: return 15;
			default: return k - 3;
		endcase
	endfunction

	// Expected supplier bit, relative to bit 16; -1 when only the catch-all applies
	function automatic int sup_bit(input logic [1:0] v, input int s);
		case (s)
			0, 1, 2, 3: return s + 1;
			4: return (v == 2'd2) ? 5 : -1;
			5: return (v == 2'd1) ? -1 : 6;
			6, 7, 8, 9: return (v == 2'd1) ? s : -1;
			default: return (v == 2'd2) ? s + 1 : -1;
		endcase
	endfunction

	task automatic final_report();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] v);
		@(posedge i_clk_sys);
		i_nrst <= 1'b0;
		i_variant <= v;
		repeat (6) @(posedge i_clk_sys);
		`CHK("event_in_reset", 1'b0, o_event_q)
		`CHK("programmed_in_reset", 1'b0, o_cfg_programmed_q)
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
	endtask

	task automatic write_cfg(input logic [63:0] w);
		@(posedge i_clk_sys);
		i_cfg_wr_en <= 1'b1;
		i_cfg_wdata <= w;
		@(posedge i_clk_sys);
		i_cfg_wr_en <= 1'b0;
	endtask

	task automatic read_chk(input logic [63:0] e);
		@(posedge i_clk_sys);
		i_cfg_rd_en <= 1'b1;
		@(posedge i_clk_sys);
		i_cfg_rd_en <= 1'b0;
		#1;
		`CHK("cfg_rdata", e, o_cfg_rdata_q)
	endtask

	// Request taken at one edge, pulse shows one edge later and stands one cycle
	task automatic req_chk(input int k, input int s, input logic [6:0] n, input logic e);
		@(posedge i_clk_sys);
		i_req_valid <= 1'b1;
		i_req_kind <= ofr_pkg::ofr_req_kind_e'(k);
		i_rsp_supplier <= ofr_pkg::ofr_supplier_e'(s);
		i_rsp_snoop <= n;
		@(posedge i_clk_sys);
		i_req_valid <= 1'b0;
		#1;
		`CHK("event_early", 1'b0, o_event_q)
		@(posedge i_clk_sys);
		#1;
		`CHK("event", e, o_event_q)
		@(posedge i_clk_sys);
		#1;
		`CHK("event_one_cycle", 1'b0, o_event_q)
	endtask

	task automatic run(input logic [63:0] c, input int k, input int s, input logic [6:0] n,
		input logic e);
		write_cfg(c);
		req_chk(k, s, n, e);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_variants();
		int b;
		logic [14:0] one;
		for (int v = 0; v < 4; v++) begin
			do_reset(v[1:0]);
			read_chk(64'h0);
			write_cfg({64{1'b1}});
			read_chk(cfg(16'h8fff, sup_wr[v], 7'h7f));
			`CHK("programmed", 1'b1, o_cfg_programmed_q)
			for (int s = 0; s < 13; s++) begin
				b = sup_bit(v[1:0], s);
				one = (b < 0) ? 15'h0 : (15'h1 << b);
				run(cfg(16'h0001, 15'h0001, 7'h7f), 0, s, 7'h01, 1'b1);
				run(cfg(16'h0001, sup_wr[v] & ~15'h0001 & ~one, 7'h7f), 0, s, 7'h01, 1'b0);
				if (b >= 0) begin
					run(cfg(16'h0001, one, 7'h7f), 0, s, 7'h01, 1'b1);
				end
			end
		end
		$display("test variants done");
	endtask

	task automatic test_kinds();
		logic [15:0] one;
		do_reset(2'd2);
		for (int k = 0; k < 17; k++) begin
			one = 16'h1 << req_bit(k);
			run(cfg(one, 15'h0001, 7'h7f), k, 1, 7'h10, 1'b1);
			run(cfg(16'hffff & ~one, 15'h0001, 7'h7f), k, 1, 7'h10, 1'b0);
		end
		$display("test kinds done");
	endtask

	task automatic test_snoop();
		run(cfg(16'h0001, 15'h0001, 7'h00), 0, 1, 7'h7f, 1'b0);
		run(cfg(16'h0001, 15'h0001, 7'h02), 0, 1, 7'h01, 1'b0);
		run(cfg(16'h0001, 15'h0001, 7'h41), 0, 1, 7'h40, 1'b1);
		run(cfg(16'h0000, 15'h0001, 7'h7f), 0, 1, 7'h7f, 1'b0);
		$display("test snoop done");
	endtask

	task automatic test_freeze();
		write_cfg(cfg(16'h0001, 15'h0001, 7'h7f));
		@(posedge i_clk_sys);
		i_req_valid <= 1'b1;
		i_req_kind <= ofr_pkg::OFR_RQ_DEMAND_DATA;
		@(posedge i_clk_sys);
		i_req_valid <= 1'b0;
		i_clk_en <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_clk_en <= 1'b1;
		#1;
		`CHK("event_frozen", 1'b0, o_event_q)
		@(posedge i_clk_sys);
		#1;
		`CHK("event_after_freeze", 1'b1, o_event_q)
		@(posedge i_clk_sys);
		#1;
		`CHK("event_stage", 1'b0, o_event_q)
		$display("test freeze done");
	endtask

	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		failures = 0;
		checked = 0;
		cycles = 0;
		i_nrst = 1'b0;
		i_clk_en = 1'b1;
		i_variant = 2'd0;
		i_cfg_wr_en = 1'b0;
		i_cfg_wdata = 64'h0;
		i_cfg_rd_en = 1'b0;
		i_req_valid = 1'b0;
		i_req_kind = ofr_pkg::OFR_RQ_DEMAND_DATA;
		i_rsp_supplier = ofr_pkg::OFR_SP_NONE;
		i_rsp_snoop = 7'h00;
		test_variants();
		test_kinds();
		test_snoop();
		test_freeze();
		final_report();
	end
endmodule
